// *** hw/wic_counter.v ***
// wrap interval counter: 16-bit prescaler feeding a 32-bit wrapping counter
// assumes oscillator ticks arrive as asynchronous square waves, sampled on REF_CLK
`timescale 1ns/1ps
`include "wic_regs.vh"
// What this block does
// - 32-bit up-counter advanced from a 16-bit prescaler that runs while enabled
// - prescaler runs from RC oscillator or 32 kHz oscillator, selectable
// - any prescaler stage may be chosen as the counter clock
// - finest tap gives 16 kHz counting from the 32 kHz source
// - prescaler not writable; software strobe clears it to zero
// - wrap at top value raises an interrupt each wrap period
// - counting continues in all sleep states except static
// - counter rate is source divided by two to the tap plus one
// - count up to top, then wrap to zero and set wrap flag
// - prescaler advances only once the enable bit is set
// - busy while a write crosses; further writes are discarded
module wic_counter #(
  parameter CNT_W  = `WIC_CNT_W,
  parameter PRE_W  = `WIC_PRE_W,
  parameter PSEL_W = `WIC_PSEL_W
) (
  input  wire              REF_CLK,
  input  wire              RESET,
  input  wire              RC_OSC,
  input  wire              XTAL_OSC,
  input  wire              STATIC_SLEEP,
  input  wire              CTRL_WR,
  input  wire              EN_IN,
  input  wire              CLK32_IN,
  input  wire [PSEL_W-1:0] PSEL_IN,
  input  wire              WAKE_EN_IN,
  input  wire              PCLR_STROBE,
  input  wire              VAL_WR,
  input  wire [CNT_W-1:0]  VAL_IN,
  input  wire              TOP_WR,
  input  wire [CNT_W-1:0]  TOP_IN,
  input  wire              IRQ_ENABLE,
  input  wire              IRQ_DISABLE,
  input  wire              WRAP_CLEAR,
  output reg               EN,
  output reg               CLK32,
  output reg  [PSEL_W-1:0] PSEL,
  output reg               WAKE_EN,
  output wire              BUSY,
  output reg  [CNT_W-1:0]  VAL,
  output reg  [CNT_W-1:0]  TOP,
  output reg               IRQ_MASK,
  output reg               WRAP_FLAG,
  output wire              IRQ,
  output wire              WAKEUP
);
  wire rc_s;
  wire xt_s;
  wire stat_s;
  reg  src_prev;
  reg  [PRE_W-1:0]  pre;
  reg  [PRE_W-1:0]  pre_prev;
  reg  [1:0]        busy_cnt;
  wire              src_sel;
  wire              src_rise;
  wire              tap_rise;
  wire              accept;
  wire              count_tick;
  wire              wrap_hit;
  wire              val_load;
  reg  [1:0]        next_busy_cnt;
  reg               next_en;
  reg               next_clk32;
  reg  [PSEL_W-1:0] next_psel;
  reg               next_wake_en;
  reg  [PRE_W-1:0]  next_pre;
  reg  [CNT_W-1:0]  next_val;
  reg  [CNT_W-1:0]  next_top;
  reg               next_irq_mask;
  reg               next_wrap_flag;

  wic_sync u_sync_rc (
    .clk (REF_CLK),
    .rst (RESET),
    .d   (RC_OSC),
    .q   (rc_s)
  );
  wic_sync u_sync_xt (
    .clk (REF_CLK),
    .rst (RESET),
    .d   (XTAL_OSC),
    .q   (xt_s)
  );
  wic_sync u_sync_st (
    .clk (REF_CLK),
    .rst (RESET),
    .d   (STATIC_SLEEP),
    .q   (stat_s)
  );

  // source choice
  assign src_sel  = CLK32 ? xt_s : rc_s;
  // static sleep halts both prescaler and counter; other sleeps do not
  assign src_rise = src_sel & ~src_prev & EN & ~stat_s;
  // rising edge of chosen stage: divides source by 2^(PSEL+1)
  assign tap_rise = pre[PSEL] & ~pre_prev[PSEL];

  // writes land on the next cycle and open a short busy window; writes during it are dropped
  assign BUSY   = (busy_cnt != 2'h0);
  assign accept = ~BUSY;

  always @(posedge REF_CLK) begin
    if (RESET) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_sel;
    end
  end

  // busy window and control shadow; one accepted write opens the window
  // limitation: oscillators must stay below a quarter of REF_CLK or edges are lost
  always @* begin
    next_busy_cnt = busy_cnt;
    next_en       = EN;
    next_clk32    = CLK32;
    next_psel     = PSEL;
    next_wake_en  = WAKE_EN;
    if (accept && (CTRL_WR || VAL_WR || TOP_WR)) begin
      next_busy_cnt = 2'h3;
    end else if (BUSY) begin
      next_busy_cnt = busy_cnt - 2'h1;
    end
    if (accept && CTRL_WR) begin
      next_en      = EN_IN;
      next_clk32   = CLK32_IN;
      next_psel    = PSEL_IN;
      next_wake_en = WAKE_EN_IN;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      EN       <= 1'b0;
      CLK32    <= 1'b0;
      PSEL     <= `WIC_PSEL_RESET;
      WAKE_EN  <= 1'b0;
      busy_cnt <= 2'h0;
    end else begin
      EN       <= next_en;
      CLK32    <= next_clk32;
      PSEL     <= next_psel;
      WAKE_EN  <= next_wake_en;
      busy_cnt <= next_busy_cnt;
    end
  end

  always @* begin
    next_pre = pre;
    if (PCLR_STROBE) begin
      next_pre = {PRE_W{1'b0}};
    end else if (src_rise) begin
      next_pre = pre + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      pre      <= {PRE_W{1'b0}};
      pre_prev <= {PRE_W{1'b0}};
    end else begin
      pre      <= next_pre;
      // clearing the history too keeps a cleared tap from faking an edge
      pre_prev <= PCLR_STROBE ? {PRE_W{1'b0}} : pre;
    end
  end

  assign count_tick = tap_rise & EN & ~stat_s;
  assign wrap_hit   = count_tick & (VAL == TOP);
  assign val_load   = accept & VAL_WR;

  always @* begin
    next_val       = VAL;
    next_top       = TOP;
    next_irq_mask  = IRQ_MASK;
    next_wrap_flag = WRAP_FLAG;
    if (accept && TOP_WR) begin
      next_top = TOP_IN;
    end
    if (val_load) begin
      next_val = VAL_IN;
    end else if (wrap_hit) begin
      next_val = `WIC_VAL_RESET;
    end else if (count_tick) begin
      next_val = VAL + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    if (IRQ_ENABLE) begin
      next_irq_mask = 1'b1;
    end else if (IRQ_DISABLE) begin
      next_irq_mask = 1'b0;
    end
    // set beats clear in the same cycle
    if (wrap_hit && !val_load) begin
      next_wrap_flag = 1'b1;
    end else if (WRAP_CLEAR) begin
      next_wrap_flag = 1'b0;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      VAL       <= `WIC_VAL_RESET;
      TOP       <= `WIC_TOP_RESET;
      IRQ_MASK  <= 1'b0;
      WRAP_FLAG <= 1'b0;
    end else begin
      VAL       <= next_val;
      TOP       <= next_top;
      IRQ_MASK  <= next_irq_mask;
      WRAP_FLAG <= next_wrap_flag;
    end
  end

  assign IRQ    = WRAP_FLAG & IRQ_MASK;
  assign WAKEUP = WRAP_FLAG & WAKE_EN;
endmodule // wic_counter

// *** common/wic_regs.vh ***
// constants for the wrap interval counter
// assumes plain verilog-2005 includers
`ifndef WIC_REGS_VH
`define WIC_REGS_VH
`define WIC_CNT_W        32
`define WIC_PRE_W        16
`define WIC_PSEL_W       4
`define WIC_SYNC_STAGES  2
`define WIC_VAL_RESET    32'h00000000
`define WIC_TOP_RESET    32'h00000000
`define WIC_PSEL_RESET   4'h0
// write kinds used by the bench: none, control word, counter value or top value
`define WIC_WR_NONE      2'h0
`define WIC_WR_CTRL      2'h1
`define WIC_WR_VAL       2'h2
`define WIC_WR_TOP       2'h3
`endif

// *** hw/wic_sync.v ***
// two-stage synchroniser for one level
// assumes the input comes from outside the ref_clk domain
`timescale 1ns/1ps
module wic_sync (
  input  wire clk,
  input  wire rst,
  input  wire d,
  output reg  q
);
  reg meta;
  always @(posedge clk) begin
    if (rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // wic_sync

// *** tb/wic_props.sv ***
// checker on the wrap interval counter ports
// assumes a bind into wic_counter, one REF_CLK domain
`timescale 1ns/1ps
module wic_props (
  input REF_CLK, input RESET, input CTRL_WR, input VAL_WR, input [31:0] VAL_IN,
  input TOP_WR, input [31:0] TOP_IN, input IRQ_ENABLE, input IRQ_DISABLE, input EN,
  input BUSY, input [31:0] VAL, input [31:0] TOP, input IRQ_MASK, input WRAP_FLAG, input IRQ
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  AST_IRQ: assert property (IRQ == (WRAP_FLAG & IRQ_MASK)) else $error("irq level");
  AST_BUSY: assert property ((CTRL_WR | VAL_WR | TOP_WR) & !BUSY |=> BUSY [*3] ##1 !BUSY) else $error("busy");
  AST_DROP: assert property (TOP_WR & BUSY |=> $stable(TOP)) else $error("top not dropped");
  AST_VAL: assert property (VAL_WR & !BUSY |=> VAL == $past(VAL_IN)) else $error("val load");
  AST_TOP: assert property (TOP_WR & !BUSY |=> TOP == $past(TOP_IN)) else $error("top load");
  AST_WRAP: assert property ($rose(WRAP_FLAG) |-> VAL == 0 && $past(VAL) == $past(TOP)) else $error("wrap");
  AST_MSET: assert property (IRQ_ENABLE |=> IRQ_MASK) else $error("mask set");
  AST_MCLR: assert property (IRQ_DISABLE & !IRQ_ENABLE |=> !IRQ_MASK) else $error("mask clear");
  // six cycles lets an edge already in the sync pipeline land first
  AST_HOLD: assert property (!EN [*6] ##0 !VAL_WR |=> $stable(VAL)) else $error("count when off");
endmodule // wic_props

// *** tb/tb.sv ***
// self-checking bench for wic_counter
// assumes REF_CLK 125 MHz; oscillators made here far below REF_CLK/4
`timescale 1ns/1ps
`include "wic_regs.vh"
module tb;
  reg REF_CLK=0, RESET=1, RC_OSC=0, XTAL_OSC=0, STATIC_SLEEP=0, CTRL_WR=0, EN_IN=0, CLK32_IN=0;
  reg WAKE_EN_IN=0, PCLR_STROBE=0, VAL_WR=0, TOP_WR=0, IRQ_ENABLE=0, IRQ_DISABLE=0, WRAP_CLEAR=0;
  reg [3:0] PSEL_IN=0;
  reg [31:0] VAL_IN=0, TOP_IN=0, v;
  wire EN, CLK32, WAKE_EN, BUSY, IRQ_MASK, WRAP_FLAG, IRQ, WAKEUP;
  wire [3:0] PSEL;
  wire [31:0] VAL, TOP;
  integer miscompares=0, checked=0, k, n=0;
  wic_counter u_wic_counter (.*);
  always #4 REF_CLK = ~REF_CLK;
  // crystal period 16 cycles, rc period 24 cycles
  always @(posedge REF_CLK) begin
    n <= n + 1;
    if (n % 8 == 7) XTAL_OSC <= ~XTAL_OSC;
    if (n % 12 == 11) RC_OSC <= ~RC_OSC;
  end
  task chk(input [31:0] g, input [31:0] e); begin
    checked = checked + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  end endtask
  task wr(input [1:0] s, input [31:0] d); begin
    @(posedge REF_CLK);
    CTRL_WR <= s == `WIC_WR_CTRL;
    VAL_WR <= s == `WIC_WR_VAL;
    TOP_WR <= s == `WIC_WR_TOP;
    {VAL_IN, TOP_IN} <= {d, d};
    {WAKE_EN_IN, PSEL_IN, CLK32_IN, EN_IN} <= d[6:0];
    @(posedge REF_CLK);
    {CTRL_WR, VAL_WR, TOP_WR} <= 3'h0;
    repeat (4) @(posedge REF_CLK);
    #1;
  end endtask
  task p(input [3:0] m); begin
    @(posedge REF_CLK);
    {PCLR_STROBE, IRQ_ENABLE, IRQ_DISABLE, WRAP_CLEAR} <= m;
    @(posedge REF_CLK);
    {PCLR_STROBE, IRQ_ENABLE, IRQ_DISABLE, WRAP_CLEAR} <= 4'h0;
    #1;
  end endtask
  task wf; begin
    k = 0;
    while (WRAP_FLAG !== 1'b1 && k < 999) begin
      @(posedge REF_CLK);
      k = k + 1;
    end
    if (k >= 999) miscompares = miscompares + 1;
    #1;
  end endtask
  // sampled half a count period off any step, so sync latency cannot matter
  task rate(input [6:0] c, input integer sp); begin
    wr(`WIC_WR_CTRL, c);
    v = VAL;
    wait (VAL !== v);
    v = VAL + 2;
    repeat (5 * (sp << c[5:2])) @(posedge REF_CLK);
    #1;
    chk(VAL, v);
  end endtask
  task report_and_stop; begin
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  initial begin
    repeat (16) @(posedge REF_CLK);
    RESET <= 0;
    @(posedge REF_CLK);
    TOP_WR <= 1;
    TOP_IN <= 5;
    @(posedge REF_CLK);
    TOP_IN <= 9;
    #1 chk(BUSY, 1);
    @(posedge REF_CLK);
    TOP_WR <= 0;
    repeat (4) @(posedge REF_CLK);
    #1;
    chk(TOP, 5);
    chk(BUSY, 0);
    chk(VAL, 0);
    wr(`WIC_WR_TOP, 32'hFFFFFFFF);
    rate(7'h03, 16);
    rate(7'h0B, 16);
    rate(7'h01, 24);
    @(posedge REF_CLK);
    STATIC_SLEEP <= 1;
    repeat (8) @(posedge REF_CLK);
    v = VAL;
    repeat (300) @(posedge REF_CLK);
    STATIC_SLEEP <= 0;
    #1;
    chk(VAL, v);
    wr(`WIC_WR_CTRL, 0);
    wr(`WIC_WR_VAL, 0);
    wr(`WIC_WR_TOP, 2);
    p(8);
    wr(`WIC_WR_CTRL, 7'h43);
    chk({WAKE_EN, PSEL, CLK32, EN}, 7'h43);
    wf;
    chk(VAL, 0);
    chk({IRQ, WAKEUP}, 1);
    p(4);
    chk(IRQ_MASK, 1);
    chk(IRQ, 1);
    p(1);
    chk(WRAP_FLAG, 0);
    wf;
    chk(k < 97, 1);
    p(2);
    chk(IRQ_MASK, 0);
    chk(IRQ, 0);
    report_and_stop;
  end
  initial begin
    #100000;
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule // tb
bind wic_counter wic_props u_wic_props (.*);
